// ---- acc_map.vh ----
// Register offsets, field positions, reset values and timing counts
// for the converter control block. Assumes inclusion by bare name.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// Register word offsets (8-bit registers, byte addresses)
`define ACC_CTRL_OFS 4'h0
`define ACC_INCLK_OFS 4'h1
`define ACC_REFAMP_OFS 4'h2
`define ACC_DATAL_OFS 4'h3
`define ACC_DATAH_OFS 4'h4

// Control register bit positions
`define ACC_CTRL_START 7
`define ACC_CTRL_BUSY 6
`define ACC_CTRL_EN 5
`define ACC_CTRL_FMT 4

// Reset values
`define ACC_CTRL_RST 8'h00
`define ACC_INCLK_RST 8'h00
`define ACC_REFAMP_RST 8'h00

// Read masks of implemented bits
`define ACC_INCLK_MASK 8'hf7
`define ACC_REFAMP_MASK 8'h9f

// Conversion timing in conversion clock cycles
`define ACC_SAMPLE_CYC 5'h04
`define ACC_TOTAL_CYC 5'h10

// Reference select codes
`define ACC_REF_SUPPLY 2'h0
`define ACC_REF_EXTPIN 2'h1

`endif

// ---- acc_clkdiv.v ----
// Conversion clock divider: one-cycle enable pulse every 2**sel system clocks.
// Assumes a single system clock; held in reset while converter is off.
module acc_clkdiv (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rstn,
    // Control
    input wire i_run,
    input wire [2:0] i_sel,
    // Tick out
    output reg o_tick
);
    // ------------------------------------------------------------
    // Divider counter
    // ------------------------------------------------------------
    reg [6:0] cnt_reg; // Free counter, cleared while disabled
    wire [6:0] lim = (7'h01 << i_sel) - 7'h01; // Terminal count

    // Counter runs only when enabled
    always @(posedge i_core_clk) begin
        if (!i_rstn || !i_run) begin
            cnt_reg <= 7'h00;
            o_tick <= 1'b0;
        end else if (cnt_reg >= lim) begin
            // Terminal count: emit tick, ratio 2**sel
            cnt_reg <= 7'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
            o_tick <= 1'b0;
        end
    end
endmodule // acc_clkdiv

// ---- acc_seq.v ----
// Conversion sequencer: counts 16 conversion clocks, 4 sampling then 12.
// Assumes ticks from the divider; start pulse is one system cycle.
`include "acc_map.vh"
module acc_seq (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rstn,
    // Control
    input wire i_hold,
    input wire i_go,
    input wire i_tick,
    // Status
    output reg o_sampling,
    output reg o_done
);
    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    reg [4:0] cnt_reg; // Conversion clocks elapsed
    reg act_reg; // Conversion in progress

    // Sequencer: reset by hold, started by go
    always @(posedge i_core_clk) begin
        if (!i_rstn || i_hold) begin
            cnt_reg <= 5'h00;
            act_reg <= 1'b0;
            o_done <= 1'b0;
            o_sampling <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_go) begin
                cnt_reg <= 5'h00;
                act_reg <= 1'b1;
                o_sampling <= 1'b1;
            end else if (act_reg && i_tick) begin
                // 4 sample clocks then 12 convert clocks
                if (cnt_reg == `ACC_TOTAL_CYC - 5'h01) begin
                    act_reg <= 1'b0;
                    o_done <= 1'b1;
                    o_sampling <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                    o_sampling <= (cnt_reg + 5'h01) < `ACC_SAMPLE_CYC;
                end
            end
        end
    end
endmodule // acc_seq

// ---- acc_ctrl.v ----
// Converter control: registers, input routing, reference and amplifier
// control, start handshake, busy flag and completion request.
// Assumes one system clock; analog converter delivers result on i_result.
// Conversion timing, in system clock edges after the edge that takes the
// write clearing the start bit:
//   +1   busy set, sequencer loaded, divider counting from zero
//   +2   sampling output raised for the first four conversion clocks
//   end  busy cleared, result captured, completion pulse, one edge
// The divider sits in reset with the converter while start is high, so
// every conversion begins on a fresh conversion clock period and lasts
// sixteen whole periods instead of fifteen and a fraction.
// Limitation: a start bit cleared by the same write that clears the
// enable bit begins nothing; enable must already be set.
// Every analog control output is registered, so each switch follows
// its register field one edge after the write has landed.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`include "acc_map.vh"
module acc_ctrl (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rstn,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Converter core
    input wire [11:0] i_result,
    output reg o_conv_clk_en,
    output reg o_conv_reset,
    output reg o_sampling,
    output reg o_conv_power,
    // Input routing
    output reg o_ext_channel_en,
    output reg [3:0] o_external_channel_field,
    output reg [2:0] o_internal_sel,
    // Reference and amplifier
    output reg o_ref_supply_en,
    output reg o_ref_extpin_en,
    output reg o_ref_amp_en,
    output reg o_ref_amplifier_enable,
    output reg o_amplifier_input_select,
    output reg [1:0] o_amplifier_gain_field,
    // Completion request
    output reg o_done_irq
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg start_reg; // Start bit
    reg busy_reg; // Conversion busy flag, read only
    reg en_reg; // Converter power enable
    reg fmt_reg; // Data format select
    reg [3:0] chan_reg; // External channel field
    reg [3:0] src_reg; // Input source field
    reg [2:0] ckdiv_reg; // Conversion clock divider field
    reg amp_en_reg; // Amplifier enable
    reg amp_in_reg; // Amplifier input select
    reg [1:0] ref_reg; // Reference select field
    reg [1:0] gain_reg; // Amplifier gain field
    reg [11:0] data_reg; // Conversion result
    reg start_fall_reg; // Start falling edge seen, one cycle

    wire tick; // Conversion clock enable
    wire seq_done; // Conversion end pulse
    wire seq_samp; // Sampling phase

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // True for source codes that route an external channel
    function is_external;
        input [3:0] src;
        begin
            is_external = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'h3);
        end
    endfunction

    // Internal signal index: 1..3 supply ratios, 5..7 amplified ratios, else 0
    function [2:0] internal_code;
        input [3:0] src;
        begin
            if (is_external(src) || src[3]) begin
                internal_code = 3'h0;
            end else begin
                internal_code = src[2:0];
            end
        end
    endfunction

    // One byte of the result as software sees it; hi picks the upper register
    function [7:0] data_byte;
        input hi;
        input fmt;
        input [11:0] d;
        begin
            if (fmt) begin
                // Right aligned: low byte full, high byte padded with zeros
                data_byte = hi ? {4'h0, d[11:8]} : d[7:0];
            end else begin
                // Left aligned: high byte full, low nibble reads zero
                data_byte = hi ? d[11:4] : {d[3:0], 4'h0};
            end
        end
    endfunction

    // Reference path switches as {amplifier, external pin, supply}
    function [2:0] ref_paths;
        input [1:0] sel;
        begin
            case (sel)
                `ACC_REF_SUPPLY: ref_paths = 3'h1;
                `ACC_REF_EXTPIN: ref_paths = 3'h2;
                // Amplifier output: both pin paths cut off
                default: ref_paths = 3'h4;
            endcase
        end
    endfunction

    wire wr_ctrl = i_wr && (i_addr == `ACC_CTRL_OFS);
    wire start_w = i_wdata[`ACC_CTRL_START];
    // Converter held in reset: start bit high or power off. The divider
    // shares it so no conversion starts on a partial clock period.
    wire conv_hold = start_reg || !en_reg;

    // ------------------------------------------------------------
    // Register writes and start handshake
    // ------------------------------------------------------------
    // Software writes; busy and result are owned by hardware
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            // Every field back to its power-on value
            start_reg <= 1'b0;
            en_reg <= 1'b0;
            fmt_reg <= 1'b0;
            chan_reg <= 4'h0;
            src_reg <= 4'h0;
            ckdiv_reg <= 3'h0;
            amp_en_reg <= 1'b0;
            amp_in_reg <= 1'b0;
            ref_reg <= 2'h0;
            gain_reg <= 2'h0;
            start_fall_reg <= 1'b0;
        end else begin
            // Falling start edge marks conversion begin
            start_fall_reg <= wr_ctrl && start_reg && !start_w && en_reg;
            if (wr_ctrl) begin
                start_reg <= start_w;
                en_reg <= i_wdata[`ACC_CTRL_EN];
                fmt_reg <= i_wdata[`ACC_CTRL_FMT];
                chan_reg <= i_wdata[3:0];
            end
            // Bit 3 has no storage and is never written
            if (i_wr && i_addr == `ACC_INCLK_OFS) begin
                src_reg <= i_wdata[7:4];
                ckdiv_reg <= i_wdata[2:0];
            end
            // Bits 6,5 have no storage and are never written
            if (i_wr && i_addr == `ACC_REFAMP_OFS) begin
                amp_en_reg <= i_wdata[7];
                amp_in_reg <= i_wdata[4];
                ref_reg <= i_wdata[3:2];
                gain_reg <= i_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Busy flag, result capture, completion request
    // ------------------------------------------------------------
    // Hold wins the busy flag; start sets it; end clears it
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            busy_reg <= 1'b0;
            // Result cleared only by system reset, never by power off
            data_reg <= 12'h000;
            o_done_irq <= 1'b0;
        end else begin
            o_done_irq <= 1'b0;
            // Hold outranks both a start and a completion in the same cycle
            if (conv_hold) begin
                busy_reg <= 1'b0;
            end else if (start_fall_reg) begin
                busy_reg <= 1'b1;
            end else if (seq_done) begin
                busy_reg <= 1'b0;
                o_done_irq <= 1'b1;
                data_reg <= i_result; // Same edge as busy clear
            end
            // Disabled converter never touches data_reg
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    acc_clkdiv u_div (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        // Restarted with each conversion so its first period is whole
        .i_run(!conv_hold),
        .i_sel(ckdiv_reg),
        .o_tick(tick)
    );

    acc_seq u_seq (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_hold(conv_hold),
        .i_go(start_fall_reg),
        .i_tick(tick),
        .o_sampling(seq_samp),
        .o_done(seq_done)
    );

    // ------------------------------------------------------------
    // Analog control outputs, registered
    // ------------------------------------------------------------
    // Routing and reference switches follow the fields one cycle later
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_conv_clk_en <= 1'b0;
            o_conv_reset <= 1'b1;
            o_sampling <= 1'b0;
            o_conv_power <= 1'b0;
            o_ext_channel_en <= 1'b0;
            o_external_channel_field <= 4'h0;
            o_internal_sel <= 3'h0;
            o_ref_supply_en <= 1'b0;
            o_ref_extpin_en <= 1'b0;
            o_ref_amp_en <= 1'b0;
            o_ref_amplifier_enable <= 1'b0;
            o_amplifier_input_select <= 1'b0;
            o_amplifier_gain_field <= 2'h0;
        end else begin
            o_conv_clk_en <= tick;
            o_conv_reset <= conv_hold;
            // Sampling drops with the reset edge, never a cycle after it
            o_sampling <= seq_samp && !conv_hold;
            o_conv_power <= en_reg;
            // External path off for any internal source
            o_ext_channel_en <= en_reg && is_external(src_reg);
            o_external_channel_field <= chan_reg;
            o_internal_sel <= internal_code(src_reg);
            // Amplifier reference cuts off both pin paths
            {o_ref_amp_en, o_ref_extpin_en, o_ref_supply_en} <= ref_paths(ref_reg);
            o_ref_amplifier_enable <= amp_en_reg;
            o_amplifier_input_select <= amp_in_reg;
            o_amplifier_gain_field <= gain_reg;
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    // Unmapped addresses and idle cycles read zero
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `ACC_CTRL_OFS: o_rdata <= {start_reg, busy_reg, en_reg, fmt_reg, chan_reg};
                // Bit 3 held zero
                `ACC_INCLK_OFS: o_rdata <= {src_reg, 1'b0, ckdiv_reg};
                // Bits 6,5 held zero
                `ACC_REFAMP_OFS: o_rdata <= {amp_en_reg, 2'h0, amp_in_reg, ref_reg, gain_reg};
                // Result bytes in the selected alignment
                `ACC_DATAL_OFS: o_rdata <= data_byte(1'b0, fmt_reg, data_reg);
                `ACC_DATAH_OFS: o_rdata <= data_byte(1'b1, fmt_reg, data_reg);
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            // Data stand one cycle only, then the port reads zero
            o_rdata <= 8'h00;
        end
    end
endmodule // acc_ctrl

// ---- acc_ctrl_sva.sv ----
// Port-level checker for the converter control block.
// Assumes it is bound to acc_ctrl and sees only that module's ports.
module acc_ctrl_sva (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rstn,
    // Register port
    input wire [3:0] i_addr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Converter core
    input wire o_conv_clk_en,
    input wire o_conv_reset,
    input wire o_sampling,
    input wire o_conv_power,
    input wire o_done_irq,
    // Routing, reference and amplifier
    input wire o_ext_channel_en,
    input wire [2:0] o_internal_sel,
    input wire o_ref_supply_en,
    input wire o_ref_extpin_en,
    input wire o_ref_amp_en,
    input wire o_ref_amplifier_enable,
    input wire o_amplifier_input_select,
    input wire [1:0] o_amplifier_gain_field
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Single clock domain, reset disables all
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // Reserved bits read zero, read-back is compared with the outputs it drives, exclusive switches never overlap
    property p_inclk_rsvd;
        i_rd && i_addr == 4'h1 |=> o_rdata[3] == 1'b0;
    endproperty
    a_inclk_rsvd: assert property (p_inclk_rsvd) else $error("select bit 3 not zero");
    property p_refamp_rsvd;
        i_rd && i_addr == 4'h2 |=> o_rdata[6:5] == 2'h0;
    endproperty
    a_refamp_rsvd: assert property (p_refamp_rsvd) else $error("ref bits 6:5 not zero");
    property p_src_route;
        i_rd && i_addr == 4'h1 && o_conv_power |=>
            o_internal_sel == ((!o_rdata[7] && o_rdata[5:4] != 2'h0) ? o_rdata[6:4] : 3'h0);
    endproperty
    a_src_route: assert property (p_src_route) else $error("source routing wrong");
    property p_ext_off;
        o_internal_sel != 3'h0 |-> !o_ext_channel_en;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external channel left on");
    property p_amp_fields;
        i_rd && i_addr == 4'h2 |=> {o_ref_amplifier_enable, o_amplifier_input_select,
            o_amplifier_gain_field} == {o_rdata[7], o_rdata[4], o_rdata[1:0]};
    endproperty
    a_amp_fields: assert property (p_amp_fields) else $error("amplifier controls wrong");
    property p_ref_paths;
        i_rd && i_addr == 4'h2 |=> {o_ref_amp_en, o_ref_extpin_en, o_ref_supply_en} ==
            {o_rdata[3], o_rdata[3:2] == 2'h1, o_rdata[3:2] == 2'h0};
    endproperty
    a_ref_paths: assert property (p_ref_paths) else $error("reference path wrong");
    property p_amp_excl;
        o_ref_amp_en |-> !o_ref_supply_en && !o_ref_extpin_en;
    endproperty
    a_amp_excl: assert property (p_amp_excl) else $error("pin reference not cut off");
    // Sequencing of a conversion
    property p_reset_quiet;
        o_conv_reset |-> !o_sampling && !o_done_irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("activity during reset");
    property p_done_pulse;
        o_done_irq |=> !o_done_irq;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    property p_off_keeps;
        !o_conv_power |-> !o_done_irq;
    endproperty
    a_off_keeps: assert property (p_off_keeps) else $error("done while powered off");
    property p_div_held;
        !o_conv_power && !$past(o_conv_power) |-> !o_conv_clk_en;
    endproperty
    a_div_held: assert property (p_div_held) else $error("divider runs while off");
    property p_sample_min;
        $rose(o_sampling) |-> (o_sampling || o_conv_reset) [*4];
    endproperty
    a_sample_min: assert property (p_sample_min) else $error("sampling too short");
endmodule // acc_ctrl_sva

bind acc_ctrl acc_ctrl_sva u_acc_ctrl_sva (.*);

// ---- acc_ctrl_tb.sv ----
// Self-checking bench for the converter control block.
// Assumes read data one cycle after the strobe and a 4 ns core clock.
module acc_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // Design inputs, all given a value at time zero
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [11:0] i_result = 12'h000;
    // Design outputs
    wire [7:0] o_rdata;
    wire o_conv_clk_en, o_conv_reset, o_sampling, o_conv_power, o_done_irq;
    wire o_ext_channel_en, o_ref_supply_en, o_ref_extpin_en, o_ref_amp_en;
    wire o_ref_amplifier_enable, o_amplifier_input_select;
    wire [3:0] o_external_channel_field;
    wire [2:0] o_internal_sel;
    wire [1:0] o_amplifier_gain_field;
    // Bookkeeping
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    int ndone = 0;
    int tdone = 0;
    int t0, n0, lat;
    logic [11:0] r;
    logic [2:0] e;
    logic ext;

    acc_ctrl dut (.*);

    initial forever #2 i_core_clk = ~i_core_clk;
    // Cycle count and completion pulses, for latency measurement
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (o_done_irq === 1'b1) begin
            ndone <= ndone + 1;
            tdone <= cyc;
        end
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog sized well above the longest expected run
    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        print_verdict;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rc(4'h0, 8'h00);
        rc(4'h1, 8'h00);
        rc(4'h2, 8'h00);
        wr(4'h1, 8'hff);
        rc(4'h1, 8'hf7);
        wr(4'h2, 8'hff);
        rc(4'h2, 8'h9f);
        wr(4'h0, 8'h40);
        rc(4'h0, 8'h00);
        rc(4'h5, 8'h00);
        $display("test registers done");
        wr(4'h0, 8'h25); // Powered long before the first start
        for (int s = 0; s < 16; s++) begin
            wr(4'h1, {s[3:0], 4'h0});
            rc(4'h1, {s[3:0], 4'h0});
            e = (!s[3] && s[1:0] != 2'h0) ? s[2:0] : 3'h0;
            chk({5'h00, o_internal_sel}, {5'h00, e});
            ext = (s[3:0] == 4'h0) || (s[3:0] == 4'h4) || (s[3:2] == 2'h3);
            chk({3'h0, o_ext_channel_en, o_external_channel_field}, {3'h0, ext, 4'h5});
        end
        $display("test source routing done");
        // Pin-reference codes assume the pin is freed by the port logic
        for (int k = 0; k < 16; k++) begin
            wr(4'h2, {k[3], 2'h0, k[2], k[1:0], k[3:2]});
            rc(4'h2, {k[3], 2'h0, k[2], k[1:0], k[3:2]});
            chk({4'h0, o_ref_amplifier_enable, o_amplifier_input_select, o_amplifier_gain_field},
                {4'h0, k[3], k[2], k[3:2]});
            chk({5'h00, o_ref_amp_en, o_ref_extpin_en, o_ref_supply_en},
                {5'h00, k[1], k[1:0] == 2'h1, k[1:0] == 2'h0});
        end
        // Last code leaves the amplifier on and feeding the reference
        $display("test reference control done");
        // Every divider code, alternating data formats
        // Only code 7 keeps the conversion clock in range at 4 ns
        for (int d = 0; d < 8; d++) begin
            r = 12'h5a3 + 12'(d);
            @(posedge i_core_clk) i_result <= r;
            wr(4'h1, {5'h00, d[2:0]});
            wr(4'h0, {3'h5, d[0], 4'h3});
            @(posedge i_core_clk);
            #1;
            chk({6'h00, o_conv_power, o_conv_reset}, 8'h03);
            rc(4'h0, {3'h5, d[0], 4'h3});
            n0 = ndone;
            wr(4'h0, {3'h1, d[0], 4'h3});
            t0 = cyc;
            repeat (2) @(posedge i_core_clk);
            rc(4'h0, {3'h3, d[0], 4'h3});
            for (int n = 0; n < 2500 && ndone == n0; n++) @(posedge i_core_clk);
            lat = tdone - t0;
            chk({7'h00, lat >= (16 << d) && lat <= (16 << d) + 8}, 8'h01);
            rc(4'h0, {3'h1, d[0], 4'h3});
            chk(8'(ndone - n0), 8'h01);
            rc(4'h3, d[0] ? r[7:0] : {r[3:0], 4'h0});
            rc(4'h4, d[0] ? {4'h0, r[11:8]} : r[11:4]);
        end
        $display("test conversions done");
        // Abort mid-conversion, then a start while powered off
        wr(4'h0, 8'hb0);
        wr(4'h0, 8'h30);
        repeat (20) @(posedge i_core_clk);
        n0 = ndone;
        wr(4'h0, 8'hb0);
        rc(4'h0, 8'hb0);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h10);
        i_result <= 12'hfff;
        wr(4'h0, 8'h90);
        wr(4'h0, 8'h10); // Left off while unused
        repeat (100) @(posedge i_core_clk);
        chk({7'h00, o_conv_power}, 8'h00);
        chk(8'(ndone - n0), 8'h00);
        rc(4'h3, 8'haa);
        rc(4'h4, 8'h05);
        $display("test abort and power off done");
        print_verdict;
    end
endmodule // acc_ctrl_tb
